/* core/camera_link_sync_decoder.sv */
// camera link receiver back end: sync code decode and byte output
// Summary of operation
// - run low drives every output low
// - outputs hold reset state during power-down
// - leaving power-down restarts from reset state
// - output updates disabled throughout power-down
// - output updates resume after power-down ends
// - power-down holds all logic reset except the pin synchronisers and prev line levels
// - frame and line codes set or clear markers
// - class select picks strobe or clock mode
// - in strobe mode exactly one line changes per bit
// - code byte carries channel and type
module camera_link_sync_decoder
  import link_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control pins, asynchronous
  input wire logic runEnable,
  input wire logic syncSelect,
  input wire logic classSelect,
  // link lines, asynchronous
  input wire linkPins_t linkPins,
  // host side
  output logic frameMarker,
  output logic lineMarker,
  output logic [7:0] parallelByteOut,
  output logic byteClockOut,
  output logic linkError
);

  typedef struct packed {
    logic [1:0] runSync;
    logic [1:0] syncSelSync;
    logic [1:0] classSync;
    logic [31:0] shift;
    logic [2:0] bitCount;
    logic [7:0] byteOut;
    logic [1:0] clkCnt;
    logic byteClk;
    logic frame;
    logic line;
    logic err;
  } decState_t;

  localparam decState_t DEC_RESET = '0;

  decState_t st_q;
  decState_t st_d;
  bitEvent_t bitEvt;
  logic ce;
  logic decodeOn;
  logic [31:0] shiftNext;
  logic [3:0] codeType;
  logic syncHit;
  logic byteDone;

  // ----------------------------------------------------------------
  // bit recovery
  // ----------------------------------------------------------------
  link_bit_recovery bitRecovery (
    .clock(clock),
    .rst_n(rst_n),
    .clear(!ce),
    .strobeMode(st_q.classSync[1]),
    .pins(linkPins),
    .bitEvt(bitEvt)
  );

  // ----------------------------------------------------------------
  // sync code detection
  // ----------------------------------------------------------------
  // a match realigns the byte counter, so byte framing is only
  // trusted from the first sync code onward
  assign ce = st_q.runSync[1];
  assign decodeOn = st_q.syncSelSync[1];
  assign shiftNext = {bitEvt.value, st_q.shift[31:1]};
  assign codeType = shiftNext[CODE_LSB +: 4];
  assign syncHit = bitEvt.valid
    && shiftNext[23:0] == SYNC_PREFIX
    && !shiftNext[CHAN_MSB]
    && shiftNext[TYPE_HI_MSB:TYPE_HI_LSB] == TYPE_HI_ZERO;
  assign byteDone = bitEvt.valid && (syncHit || st_q.bitCount == BIT_LAST);

  // next state
  always_comb begin
    st_d = st_q;
    st_d.err = bitEvt.error;
    st_d.byteClk = st_q.clkCnt != 2'h0;
    if (st_q.clkCnt != 2'h0) begin
      st_d.clkCnt = 2'(st_q.clkCnt - 2'h1);
    end
    if (bitEvt.valid) begin
      st_d.shift = shiftNext;
      st_d.bitCount = syncHit ? 3'h0 : 3'(st_q.bitCount + 3'h1);
    end
    // bytes, sync codes included, go out in both modes
    if (byteDone) begin
      st_d.byteOut = shiftNext[CODE_LSB +: 8];
      st_d.clkCnt = OUT_CLK_HIGH_CYCLES;
    end
    if (!decodeOn) begin
      st_d.frame = 1'b0;
      st_d.line = 1'b0;
    end else if (syncHit) begin
      case (codeType)
        CODE_FRAME_START: begin
          st_d.frame = 1'b1;
          st_d.line = 1'b1;
        end
        CODE_FRAME_END: begin
          st_d.frame = 1'b0;
          st_d.line = 1'b0;
        end
        CODE_LINE_START: st_d.line = 1'b1;
        CODE_LINE_END: st_d.line = 1'b0;
        default: st_d.line = st_q.line;
      endcase
    end
    // power-down: everything but the pin synchronisers sits in reset
    if (!ce) begin
      st_d = DEC_RESET;
    end
    st_d.runSync = {st_q.runSync[0], runEnable};
    st_d.syncSelSync = {st_q.syncSelSync[0], syncSelect};
    st_d.classSync = {st_q.classSync[0], classSelect};
  end

  // state register; released state restarts from reset on run high
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= DEC_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, straight from flops
  // ----------------------------------------------------------------
  assign frameMarker = st_q.frame;
  assign lineMarker = st_q.line;
  assign parallelByteOut = st_q.byteOut;
  assign byteClockOut = st_q.byteClk;
  assign linkError = st_q.err;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence powerDownTwo;
    !ce ##1 !ce;
  endsequence

  sequence frameStartSeen;
    ce && decodeOn && syncHit && codeType == CODE_FRAME_START;
  endsequence

  sequence lineEndSeen;
    ce && decodeOn && syncHit && codeType == CODE_LINE_END;
  endsequence

  AST_OFF_OUTPUTS_LOW: assert property (
    @(posedge clock) disable iff (!rst_n)
    !ce |=> !frameMarker && !lineMarker && parallelByteOut == 8'h00
      && !byteClockOut && !linkError)
    else $error("outputs not low in power-down");

  AST_OFF_NO_TOGGLE: assert property (
    @(posedge clock) disable iff (!rst_n)
    powerDownTwo |=> $stable({frameMarker, lineMarker, parallelByteOut,
      byteClockOut}))
    else $error("output toggled in power-down");

  AST_RESTART_FROM_RESET: assert property (
    @(posedge clock) disable iff (!rst_n)
    $rose(ce) |-> st_q.shift == 32'h0000_0000 && st_q.bitCount == 3'h0
      && st_q.clkCnt == 2'h0)
    else $error("restart did not begin from reset state");

  AST_OFF_INTERNAL_RESET: assert property (
    @(posedge clock) disable iff (!rst_n)
    !ce ##1 !ce |-> !bitEvt.valid && st_q.shift == 32'h0000_0000)
    else $error("internal state moved in power-down");

  AST_RESUME_UPDATE: assert property (
    @(posedge clock) disable iff (!rst_n)
    ce && byteDone |=> parallelByteOut == $past(shiftNext[31:24])
      ##1 byteClockOut [*2] ##1 !byteClockOut)
    else $error("byte or output clock wrong after byte completed");

  AST_FRAME_START_MARKERS: assert property (
    @(posedge clock) disable iff (!rst_n)
    frameStartSeen ##1 ce |-> frameMarker && lineMarker)
    else $error("frame start did not raise both markers");

  AST_LINE_END_MARKER: assert property (
    @(posedge clock) disable iff (!rst_n)
    lineEndSeen ##1 ce |-> !lineMarker && frameMarker == $past(frameMarker))
    else $error("line end marker behaviour wrong");

  AST_PASS_MODE_LOW: assert property (
    @(posedge clock) disable iff (!rst_n)
    ce && !decodeOn |=> !frameMarker && !lineMarker)
    else $error("markers active with decoding off");

  AST_ERROR_FLAG: assert property (
    @(posedge clock) disable iff (!rst_n)
    ce && bitEvt.error |=> linkError)
    else $error("link error not reported");

endmodule : camera_link_sync_decoder

/* core/link_pkg.sv */
// constants and carrier types shared by the link sync decoder files
package link_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 40;
  localparam int OUT_CLK_HIGH_NS = 80;
  // least time, rounded up to whole cycles
  localparam logic [1:0] OUT_CLK_HIGH_CYCLES =
    2'((OUT_CLK_HIGH_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

  // ----------------------------------------------------------------
  // sync code layout: bytes FF 00 00 then channel/type, lsb first
  // ----------------------------------------------------------------
  localparam logic [23:0] SYNC_PREFIX = 24'h0000FF;
  localparam int CODE_LSB = 24;
  localparam int CHAN_MSB = 31;
  localparam int TYPE_HI_MSB = 27;
  localparam int TYPE_HI_LSB = 26;
  localparam logic [1:0] TYPE_HI_ZERO = 2'h0;
  localparam logic [3:0] CODE_LINE_START = 4'h0;
  localparam logic [3:0] CODE_LINE_END = 4'h1;
  localparam logic [3:0] CODE_FRAME_START = 4'h2;
  localparam logic [3:0] CODE_FRAME_END = 4'h3;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // ----------------------------------------------------------------
  // idle line levels at the start of a transmission
  // ----------------------------------------------------------------
  localparam logic IDLE_DATA = 1'h1;
  localparam logic IDLE_STROBE = 1'h0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic data;
    logic strobePairPos;
  } linkPins_t;

  typedef struct packed {
    logic valid;
    logic value;
    logic error;
  } bitEvent_t;

endpackage : link_pkg

/* core/link_bit_recovery.sv */
// serial bit recovery from data/strobe or data/clock link lines
module link_bit_recovery
  import link_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control from the decoder
  input wire logic clear,
  input wire logic strobeMode,
  // link lines, asynchronous to clock
  input wire linkPins_t pins,
  // recovered bit
  output bitEvent_t bitEvt
);

  typedef struct packed {
    logic [1:0] dataSync;
    logic [1:0] strbSync;
    logic dataPrev;
    logic strbPrev;
    bitEvent_t evt;
  } recState_t;

  localparam recState_t REC_RESET = '{
    dataSync: {IDLE_DATA, IDLE_DATA},
    strbSync: {IDLE_STROBE, IDLE_STROBE},
    dataPrev: IDLE_DATA,
    strbPrev: IDLE_STROBE,
    evt: '0
  };

  recState_t rec_q;
  recState_t rec_d;
  logic dataNow;
  logic strbNow;
  logic dataChg;
  logic strbChg;

  assign dataNow = rec_q.dataSync[1];
  assign strbNow = rec_q.strbSync[1];
  assign dataChg = dataNow ^ rec_q.dataPrev;
  assign strbChg = strbNow ^ rec_q.strbPrev;

  // ----------------------------------------------------------------
  // sampling and edge decode
  // ----------------------------------------------------------------
  // prev levels always track the lines, so leaving power-down never
  // sees a false edge from whatever the idle levels were
  always_comb begin
    rec_d = rec_q;
    rec_d.dataSync = {rec_q.dataSync[0], pins.data};
    rec_d.strbSync = {rec_q.strbSync[0], pins.strobePairPos};
    rec_d.dataPrev = dataNow;
    rec_d.strbPrev = strbNow;
    rec_d.evt.value = dataNow;
    if (strobeMode) begin
      rec_d.evt.valid = dataChg ^ strbChg;
      rec_d.evt.error = dataChg & strbChg;
    end else begin
      rec_d.evt.valid = strbNow & ~rec_q.strbPrev;
      rec_d.evt.error = 1'b0;
    end
    if (clear) begin
      rec_d.evt = '0;
    end
  end

  // state register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rec_q <= REC_RESET;
    end else begin
      rec_q <= rec_d;
    end
  end

  assign bitEvt = rec_q.evt;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_BOTH_CHANGE_ERROR: assert property (
    @(posedge clock) disable iff (!rst_n)
    strobeMode && dataChg && strbChg && !clear
      |=> bitEvt.error && !bitEvt.valid)
    else $error("simultaneous data and strobe change not flagged");

  AST_CLOCK_MODE_BIT: assert property (
    @(posedge clock) disable iff (!rst_n)
    !strobeMode && strbNow && !rec_q.strbPrev && !clear
      |=> bitEvt.valid && bitEvt.value == $past(dataNow))
    else $error("clock rising edge did not yield a bit");

endmodule : link_bit_recovery

/* verif/link_tx_model.sv */
// behavioural camera transmitter driving the serial link lines
module link_tx_model
  import link_pkg::*;
(
  // mode: high = data/strobe, low = data/clock
  input wire logic strobeMode,
  // link lines toward the receiver
  output linkPins_t pins
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF_NS = 160;

  // idle levels; a gated link clock rests high between frames
  task automatic rest();
    pins.data = IDLE_DATA;
    pins.strobePairPos = strobeMode ? IDLE_STROBE : 1'h1;
  endtask : rest

  // one bit; in strobe mode exactly one line moves per bit
  task automatic send_bit(input logic b);
    if (strobeMode) begin
      if (b != pins.data) pins.data = b;
      else pins.strobePairPos = ~pins.strobePairPos;
      #(2 * HALF_NS);
    end else begin
      pins.data = b;
      pins.strobePairPos = 1'h0;
      #HALF_NS;
      pins.strobePairPos = 1'h1;
      #HALF_NS;
    end
  endtask : send_bit

  // lsb first; the small lead lets link phase drift against clock
  task automatic send_byte(input logic [7:0] v);
    #7;
    for (int i = 0; i < 8; i++) send_bit(v[i]);
  endtask : send_byte

  // both lines move together, which the receiver must flag
  task automatic glitch();
    pins = ~pins;
    #(2 * HALF_NS);
  endtask : glitch
endmodule : link_tx_model

/* verif/tb_top.sv */
// self-checking bench for the camera link sync decoder
module tb_top
  import link_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ---------
  // stimulus and design
  // ---------
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic runEnable = 1'h1;
  logic syncSelect = 1'h1;
  logic classSelect = 1'h1;
  linkPins_t linkPins;
  logic frameMarker, lineMarker, byteClockOut, linkError;
  logic [7:0] parallelByteOut;
  logic [9:0] notes[$];
  logic frm = 1'h0, lin = 1'h0, armed = 1'h0, bcPrev = 1'h0;
  int err_total = 0, samples_checked = 0, seed = 97752, errSeen = 0;

  always #20 clock = ~clock;

  link_tx_model tx (.strobeMode(classSelect), .pins(linkPins));
  camera_link_sync_decoder uut (.clock(clock), .rst_n(rst_n),
    .runEnable(runEnable), .syncSelect(syncSelect),
    .classSelect(classSelect), .linkPins(linkPins),
    .frameMarker(frameMarker), .lineMarker(lineMarker),
    .parallelByteOut(parallelByteOut), .byteClockOut(byteClockOut),
    .linkError(linkError));

  // ---------
  // checking and report
  // ---------
  task automatic check(input string what, input logic [11:0] e,
                       input logic [11:0] s);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask : check

  task automatic tally_and_finish();
    check("pending notes", 12'h0, 12'(notes.size()));
    $display("compares %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // byte clock rising: oldest note against byte, markers and flags;
  // sampled at the falling edge so every output has settled
  always @(negedge clock) begin
    bcPrev <= byteClockOut;
    if (linkError === 1'h1) errSeen <= errSeen + 1;
    if (armed && byteClockOut === 1'h1 && bcPrev === 1'h0) begin
      if (notes.size() == 0) check("extra byte", 12'h0, 12'hFFF);
      else check("byte", {notes.pop_front(), 2'h2}, {frameMarker,
        lineMarker, parallelByteOut, byteClockOut, linkError});
    end
  end

  // ---------
  // traffic
  // ---------
  // note the byte with the markers it must carry, then send it
  task automatic send(input logic [7:0] v);
    if (armed) notes.push_back({frm, lin, v});
    tx.send_byte(v);
  endtask : send

  // sync code; an unknown type must leave the markers alone
  task automatic code(input logic [3:0] t);
    logic [2:0] ch;
    ch = 3'($random(seed));
    send(8'hFF);
    send(8'h00);
    send(8'h00);
    if (syncSelect) begin
      case (t)
        4'h0: lin = 1'h1;
        4'h1: lin = 1'h0;
        4'h2: {frm, lin} = 2'h3;
        4'h3: {frm, lin} = 2'h0;
        default: ;
      endcase
    end
    send({1'h0, ch, t});
  endtask : code

  task automatic frame();
    code(4'h2);
    send(8'($random(seed)));
    code(4'h1);
    code(4'h4);
    code(4'h0);
    send(8'($random(seed)));
    code(4'h3);
  endtask : frame

  // alignment traffic is not compared: framing is open until a code
  task automatic align();
    armed = 1'h0;
    tx.rest();
    code(4'h3);
    repeat (8) @(posedge clock);
    armed = 1'h1;
  endtask : align

  initial begin
    tx.rest();
    repeat (8) @(posedge clock);
    rst_n <= 1'h1;
    repeat (6) @(posedge clock);
    align();
    frame();
    @(posedge clock);
    syncSelect <= 1'h0;
    repeat (4) @(posedge clock);
    frame();
    syncSelect <= 1'h1;
    armed = 1'h0;
    tx.glitch();
    repeat (4) @(posedge clock);
    check("link error", 12'h1, 12'(errSeen));
    @(posedge clock);
    classSelect <= 1'h0;
    repeat (4) @(posedge clock);
    align();
    frame();
    classSelect <= 1'h1;
    repeat (4) @(posedge clock);
    align();
    code(4'h2);
    @(posedge clock);
    runEnable <= 1'h0;
    repeat (3) @(posedge clock);
    // link noise while powered down: outputs must stay low
    repeat (40) begin
      @(negedge clock);
      check("powerdown", 12'h0, {frameMarker, lineMarker,
        parallelByteOut, byteClockOut, linkError});
      tx.pins = linkPins_t'($random(seed));
    end
    tx.rest();
    @(posedge clock);
    runEnable <= 1'h1;
    repeat (6) @(posedge clock);
    {frm, lin} = 2'h0;
    code(4'h0);
    repeat (10) @(posedge clock);
    tally_and_finish();
  end
endmodule : tb_top
